// >>> rtl/vsi_mem.sv
/*
 Long-word buffer memory with byte-lane writes and registered read data.
 Assumes one clock; address in long words.
*/
`timescale 1ns/1ps
module vsi_mem #(
  parameter int ADDR_W = 15
) (
  // Clock
  input wire logic mclk_in,
  // Access
  input wire logic wr_en_in,
  input wire logic [3:0] lane_en_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  output logic [31:0] rdata_out
);
  logic [31:0] mem_ff [0:(1<<ADDR_W)-1];
  logic [31:0] rdata_ff;

  always_ff @(posedge mclk_in) begin
    for (int i = 0; i < 4; i++) begin
      if (wr_en_in && lane_en_in[i]) begin
        mem_ff[addr_in][i*8 +: 8] <= wdata_in[i*8 +: 8];
      end
    end
    rdata_ff <= mem_ff[addr_in];
  end

  assign rdata_out = rdata_ff;
endmodule

// >>> rtl/vsi_params.svh
/*
 Timing counts, window offsets and field positions of the backplane slave.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef VSI_PARAMS_SVH
`define VSI_PARAMS_SVH
`define VSI_WIN_BITS 18
`define VSI_DISK_BUF_HI 18'h0_FFFF
`define VSI_DISK_REG_LO 18'h1_0000
`define VSI_DISK_REG_HI 18'h1_0007
`define VSI_NET_CSR_OFS 18'h1_FF02
`define VSI_NET_BUF_LO 18'h2_0000
`define VSI_CSR_IRQ_BIT 8
`define VSI_CSR_IEN_BIT 12
`define VSI_CSR_CA_BIT 13
`define VSI_CSR_LB_BIT 14
`define VSI_CSR_RST_BIT 15
`define VSI_CSR_RESET 16'h0000
`define VSI_DISK_LEVEL 3'h2
`define VSI_NET_LEVEL 3'h3
`define VSI_AM_A24_DATA 6'h39
`define VSI_AM_A24_SUPV 6'h3D
`define VSI_AM_A32_DATA 6'h09
`define VSI_AM_A32_SUPV 6'h0D
`define VSI_CLK_MHZ 50
`define VSI_ACC_NS 60
`define VSI_ACC_CYC ((`VSI_ACC_NS * `VSI_CLK_MHZ + 999) / 1000)
`endif

// >>> rtl/vsi_pkg.sv
/*
 Types shared by the backplane slave files.
 Assumes vsi_params.svh supplies the numbers.
*/
package vsi_pkg;
  typedef enum logic [2:0] {
    VSI_TGT_NONE,
    VSI_TGT_DISK_BUF,
    VSI_TGT_DISK_REG,
    VSI_TGT_NET_CSR,
    VSI_TGT_NET_BUF
  } vsi_tgt_e;
  typedef enum logic [2:0] {
    VSI_ST_IDLE,
    VSI_ST_WAIT,
    VSI_ST_ACK,
    VSI_ST_RELEASE
  } vsi_state_e;
endpackage

// >>> rtl/vsi_slave.sv
/*
 Backplane slave of the disk and network board: board select, cycle control,
 data buffer, byte lane steering and the two-level interrupter.
 Assumes backplane strobes arrive asynchronously and are synchronised here;
 transceivers outside turn the enables into open-collector drive.
*/
`timescale 1ns/1ps
`include "vsi_params.svh"

module vsi_slave
  import vsi_pkg::*;
#(
  parameter logic [7:0] DISK_STATUS_ID = 8'h40, // Arbitrary default
  parameter logic [7:0] NET_STATUS_ID = 8'h41   // Arbitrary default
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // Configuration switches
  input wire logic a32_mode_in,
  input wire logic [13:0] base_sel_in,
  // Backplane address and control
  input wire logic [31:1] vme_addr_in,
  input wire logic [5:0] vme_am_in,
  input wire logic vme_as_n_in,
  input wire logic vme_ds0_n_in,
  input wire logic vme_ds1_n_in,
  input wire logic vme_lword_n_in,
  input wire logic vme_write_n_in,
  input wire logic vme_iack_n_in,
  input wire logic vme_iackin_n_in,
  // Backplane data
  input wire logic [31:0] vme_data_in,
  output logic [31:0] vme_data_out,
  output logic vme_data_oe_out,
  // Backplane response
  output logic vme_dtack_oe_out,
  output logic vme_iackout_n_out,
  output logic vme_irq2_oe_out,
  output logic vme_irq3_oe_out,
  // Disk controller register port
  output logic disk_reg_sel_out,
  output logic disk_reg_wr_out,
  output logic [2:0] disk_reg_addr_out,
  output logic [7:0] disk_reg_wdata_out,
  input wire logic [7:0] disk_reg_rdata_in,
  input wire logic disk_irq_in,
  // Network controller control
  input wire logic net_ctrl_irq_flag_in,
  output logic net_chan_attn_out,
  output logic net_loopback_out,
  output logic net_link_reset_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers on the backplane strobes, IACK lines and both interrupt flags; LWORD and WRITE are read directly
  logic [6:0] s1_ff, s2_ff;
  logic [6:0] raw_in;
  assign raw_in = {vme_as_n_in, vme_ds0_n_in, vme_ds1_n_in, vme_iack_n_in,
                   vme_iackin_n_in, disk_irq_in, net_ctrl_irq_flag_in};
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_ff <= 7'h7C;
      s2_ff <= 7'h7C;
    end else begin
      s1_ff <= raw_in;
      s2_ff <= s1_ff;
    end
  end
  logic as_n, ds0_n, ds1_n, iack_n, iackin_n, disk_irq, net_flag;
  assign {as_n, ds0_n, ds1_n, iack_n, iackin_n, disk_irq, net_flag} = s2_ff;
  logic any_ds;
  assign any_ds = !ds0_n || !ds1_n;

  ////////////////////////////////////////////////////////////////////////////
  // Board select; address lines settle before strobes, so reading them
  // directly once the strobes are synchronised is safe
  logic am_ok, base_hit;
  logic [17:0] ofs;
  assign ofs = {vme_addr_in[17:1], 1'b0};
  always_comb begin
    if (a32_mode_in) begin
      am_ok = vme_am_in == `VSI_AM_A32_DATA || vme_am_in == `VSI_AM_A32_SUPV;
      base_hit = vme_addr_in[31:18] == base_sel_in;
    end else begin
      am_ok = vme_am_in == `VSI_AM_A24_DATA || vme_am_in == `VSI_AM_A24_SUPV;
      base_hit = vme_addr_in[23:18] == base_sel_in[5:0];
    end
  end
  // Block modifiers are not in the accepted set, so they are ignored
  vsi_tgt_e tgt;
  always_comb begin
    tgt = VSI_TGT_NONE;
    if (am_ok && base_hit && iack_n) begin
      if (ofs <= `VSI_DISK_BUF_HI) tgt = VSI_TGT_DISK_BUF;
      else if (ofs >= `VSI_DISK_REG_LO && ofs <= `VSI_DISK_REG_HI)
        tgt = VSI_TGT_DISK_REG;
      else if (ofs == `VSI_NET_CSR_OFS) tgt = VSI_TGT_NET_CSR;
      else if (ofs >= `VSI_NET_BUF_LO) tgt = VSI_TGT_NET_BUF;
    end
  end

  // Byte lanes from strobes, LWORD and A1
  logic [3:0] lanes;
  logic [31:0] wdata;
  always_comb begin
    if (!vme_lword_n_in) lanes = 4'hF;
    else if (vme_addr_in[1]) lanes = {2'b00, !ds1_n, !ds0_n};
    else lanes = {!ds1_n, !ds0_n, 2'b00};
    if (!vme_lword_n_in) wdata = vme_data_in;
    else wdata = {vme_data_in[15:0], vme_data_in[15:0]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupter: the disk level is sticky until a disk register is accessed; the network level follows its flag gated by IEN
  logic [15:0] csr_ff, nxt_csr;
  logic disk_pend_ff, nxt_disk_pend;
  logic net_req;
  assign net_req = net_flag && csr_ff[`VSI_CSR_IEN_BIT];
  logic iack_hit2, iack_hit3;
  assign iack_hit2 = !iack_n && !iackin_n &&
                     vme_addr_in[3:1] == `VSI_DISK_LEVEL;
  assign iack_hit3 = !iack_n && !iackin_n &&
                     vme_addr_in[3:1] == `VSI_NET_LEVEL;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle control
  vsi_state_e st_ff, nxt_st;
  logic [2:0] cnt_ff, nxt_cnt;
  logic [31:0] rd_ff, nxt_rd;
  logic dtack_ff, nxt_dtack, doe_ff, nxt_doe, iackout_n_ff, nxt_iackout_n;
  logic dsel_ff, nxt_dsel, dwr_ff, nxt_dwr;
  logic [2:0] dadr_ff, nxt_dadr;
  logic [7:0] dwd_ff, nxt_dwd;
  logic ca_ff, nxt_ca;
  vsi_tgt_e cur_ff, nxt_cur;
  logic mem_wr;
  logic [31:0] dbuf_q, nbuf_q;

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_rd = rd_ff;
    nxt_dtack = dtack_ff;
    nxt_doe = doe_ff;
    nxt_iackout_n = 1'b1;
    nxt_dsel = 1'b0;
    nxt_dwr = 1'b0;
    nxt_dadr = dadr_ff;
    nxt_dwd = dwd_ff;
    nxt_ca = 1'b0;
    nxt_cur = cur_ff;
    nxt_csr = csr_ff;
    nxt_csr[`VSI_CSR_IRQ_BIT] = net_flag;
    nxt_disk_pend = disk_pend_ff || disk_irq;
    mem_wr = 1'b0;
    unique case (st_ff)
      VSI_ST_IDLE: begin
        // Only answers a master's strobe; nothing here starts a cycle
        if (!as_n && any_ds) begin
          if (iack_hit2 && disk_pend_ff) begin
            nxt_rd = {24'h0, DISK_STATUS_ID};
            nxt_doe = 1'b1;
            nxt_dtack = 1'b1;
            nxt_st = VSI_ST_ACK;
          end else if (iack_hit3 && net_req) begin
            nxt_rd = {24'h0, NET_STATUS_ID};
            nxt_doe = 1'b1;
            nxt_dtack = 1'b1;
            nxt_st = VSI_ST_ACK;
          end else if (!iack_n && !iackin_n) begin
            nxt_iackout_n = 1'b0; // Pass the daisy chain on
          end else if (tgt != VSI_TGT_NONE) begin
            nxt_cur = tgt;
            nxt_cnt = 3'(`VSI_ACC_CYC);
            nxt_dadr = ofs[2:0] | {2'b00, !ds0_n};
            nxt_dwd = ds0_n ? vme_data_in[15:8] : vme_data_in[7:0];
            nxt_dsel = tgt == VSI_TGT_DISK_REG;
            nxt_dwr = tgt == VSI_TGT_DISK_REG && !vme_write_n_in;
            mem_wr = !vme_write_n_in && (tgt == VSI_TGT_DISK_BUF ||
                     tgt == VSI_TGT_NET_BUF);
            if (tgt == VSI_TGT_DISK_REG) nxt_disk_pend = 1'b0;
            if (tgt == VSI_TGT_NET_CSR && !vme_write_n_in) begin
              nxt_csr[15:12] = vme_data_in[15:12];
              nxt_ca = vme_data_in[`VSI_CSR_CA_BIT];
            end
            nxt_st = VSI_ST_WAIT;
          end
        end else if (!as_n && !iack_n && !iackin_n) begin
          nxt_iackout_n = iackout_n_ff;
        end
      end
      VSI_ST_WAIT: begin
        nxt_cnt = cnt_ff - 3'h1;
        if (cnt_ff <= 3'h1) begin
          unique case (cur_ff)
            VSI_TGT_DISK_BUF: nxt_rd = dbuf_q;
            VSI_TGT_NET_BUF: nxt_rd = nbuf_q;
            VSI_TGT_DISK_REG: nxt_rd = {4{disk_reg_rdata_in}};
            default: nxt_rd = {2{csr_ff}};
          endcase
          // Short reads travel on D15:0, so the addressed half is repeated
          if (vme_lword_n_in && (cur_ff == VSI_TGT_DISK_BUF ||
              cur_ff == VSI_TGT_NET_BUF)) begin
            nxt_rd = vme_addr_in[1] ? {2{nxt_rd[15:0]}} : {2{nxt_rd[31:16]}};
          end
          nxt_doe = vme_write_n_in;
          nxt_dtack = 1'b1;
          nxt_st = VSI_ST_ACK;
        end
      end
      VSI_ST_ACK: begin
        if (!any_ds) begin
          nxt_dtack = 1'b0;
          nxt_doe = 1'b0;
          nxt_st = VSI_ST_RELEASE;
        end
      end
      VSI_ST_RELEASE: begin
        if (as_n) nxt_st = VSI_ST_IDLE; // One access per address strobe
      end
      default: nxt_st = VSI_ST_IDLE;
    endcase
    if (disk_irq) nxt_disk_pend = 1'b1; // Set wins over clear
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_ff <= VSI_ST_IDLE;
      cnt_ff <= 3'h0;
      rd_ff <= 32'h0000_0000;
      dtack_ff <= 1'b0;
      doe_ff <= 1'b0;
      iackout_n_ff <= 1'b1;
      dsel_ff <= 1'b0;
      dwr_ff <= 1'b0;
      dadr_ff <= 3'h0;
      dwd_ff <= 8'h00;
      ca_ff <= 1'b0;
      cur_ff <= VSI_TGT_NONE;
      csr_ff <= `VSI_CSR_RESET;
      disk_pend_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      rd_ff <= nxt_rd;
      dtack_ff <= nxt_dtack;
      doe_ff <= nxt_doe;
      iackout_n_ff <= nxt_iackout_n;
      dsel_ff <= nxt_dsel;
      dwr_ff <= nxt_dwr;
      dadr_ff <= nxt_dadr;
      dwd_ff <= nxt_dwd;
      ca_ff <= nxt_ca;
      cur_ff <= nxt_cur;
      csr_ff <= nxt_csr;
      disk_pend_ff <= nxt_disk_pend;
    end
  end

  // Request levels registered from the next-state pending and IEN values
  logic irq2_ff, irq3_ff;
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq2_ff <= 1'b0;
      irq3_ff <= 1'b0;
    end else begin
      irq2_ff <= nxt_disk_pend;
      irq3_ff <= net_flag && nxt_csr[`VSI_CSR_IEN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data buffer memories
  vsi_mem #(.ADDR_W(14)) u_disk_buf (
    .mclk_in(mclk_in),
    .wr_en_in(mem_wr && tgt == VSI_TGT_DISK_BUF),
    .lane_en_in(lanes),
    .addr_in(ofs[15:2]),
    .wdata_in(wdata),
    .rdata_out(dbuf_q)
  );
  vsi_mem #(.ADDR_W(15)) u_net_buf (
    .mclk_in(mclk_in),
    .wr_en_in(mem_wr && tgt == VSI_TGT_NET_BUF),
    .lane_en_in(lanes),
    .addr_in(ofs[16:2]),
    .wdata_in(wdata),
    .rdata_out(nbuf_q)
  );

  assign vme_data_out = rd_ff;
  assign vme_data_oe_out = doe_ff;
  assign vme_dtack_oe_out = dtack_ff;
  assign vme_iackout_n_out = iackout_n_ff;
  assign vme_irq2_oe_out = irq2_ff;
  assign vme_irq3_oe_out = irq3_ff;
  assign disk_reg_sel_out = dsel_ff;
  assign disk_reg_wr_out = dwr_ff;
  assign disk_reg_addr_out = dadr_ff;
  assign disk_reg_wdata_out = dwd_ff;
  assign net_chan_attn_out = ca_ff;
  assign net_loopback_out = csr_ff[`VSI_CSR_LB_BIT];
  assign net_link_reset_out = csr_ff[`VSI_CSR_RST_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_dtack_release: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    dtack_ff && !any_ds |=> !dtack_ff) else $error("dtack held");
  a_no_spurious_ack: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    $rose(dtack_ff) |-> $past(!as_n)) else $error("ack without strobe");
  a_net_gate: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    irq3_ff |-> csr_ff[`VSI_CSR_IEN_BIT]) else $error("net irq ungated");
  a_disk_sticky: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    disk_pend_ff && st_ff != VSI_ST_IDLE |=> disk_pend_ff)
    else $error("disk irq lost");
  a_iack_id: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    st_ff == VSI_ST_IDLE && !as_n && any_ds && iack_hit2 && disk_pend_ff
    |=> rd_ff[31:8] == 24'h0 && rd_ff[7:0] == DISK_STATUS_ID)
    else $error("bad status id");
  a_wait_len: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    $rose(st_ff == VSI_ST_WAIT) |-> ##[1:4] dtack_ff) else $error("ack late");
  a_unmapped: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    st_ff == VSI_ST_IDLE && tgt == VSI_TGT_NONE && iack_n |=> !dtack_ff)
    else $error("unmapped acked");
  a_one_access: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    st_ff == VSI_ST_RELEASE && !as_n |=> !dtack_ff) else $error("second ack");
  c_buf_write: cover property (@(posedge mclk_in) mem_wr);
  c_iack: cover property (@(posedge mclk_in) iack_hit3 && net_req);
  c_csr: cover property (@(posedge mclk_in) cur_ff == VSI_TGT_NET_CSR);
endmodule

// >>> tb/vme_slave_interface_tb_top.sv
/*
 Self-checking bench of the backplane slave.
 Assumes vsi_host_model drives the backplane side.
*/
`timescale 1ns/1ps
`include "vsi_params.svh"
module vme_slave_interface_tb_top;
  localparam logic [7:0] ID_D = 8'h40; // Arbitrary status/ID
  localparam logic [7:0] ID_N = 8'h41; // Arbitrary status/ID
  localparam logic [31:0] MSK = 32'hFFFF_FFFF;
  logic mclk, nrst_n, a32, dirq, nflag, ok, dt_q, nseen;
  logic [11:0] dreg;
  logic as_n, ds0_n, ds1_n, lw_n, wr_n, iack_n, iackin_n;
  logic doe, dtk, iko_n, irq2, irq3, dsel, dwr, attn, lb, lrst;
  logic [13:0] base;
  logic [7:0] drd, dwd;
  logic [31:1] va;
  logic [5:0] am;
  logic [2:0] dadr;
  logic [31:0] hd, vdo, r;
  logic [63:0] q[$];
  logic [63:0] e;
  logic [17:0] ofs[4];
  int err_total, samples_checked, seed, i;
  wire logic [31:0] vdi = doe ? vdo : hd;

  vsi_slave #(.DISK_STATUS_ID(ID_D), .NET_STATUS_ID(ID_N)) dut_u (
    .mclk_in(mclk), .nrst_in(nrst_n), .a32_mode_in(a32),
    .base_sel_in(base), .vme_addr_in(va), .vme_am_in(am),
    .vme_as_n_in(as_n), .vme_ds0_n_in(ds0_n), .vme_ds1_n_in(ds1_n),
    .vme_lword_n_in(lw_n), .vme_write_n_in(wr_n),
    .vme_iack_n_in(iack_n), .vme_iackin_n_in(iackin_n),
    .vme_data_in(vdi), .vme_data_out(vdo), .vme_data_oe_out(doe),
    .vme_dtack_oe_out(dtk), .vme_iackout_n_out(iko_n),
    .vme_irq2_oe_out(irq2), .vme_irq3_oe_out(irq3),
    .disk_reg_sel_out(dsel), .disk_reg_wr_out(dwr),
    .disk_reg_addr_out(dadr), .disk_reg_wdata_out(dwd),
    .disk_reg_rdata_in(drd), .disk_irq_in(dirq),
    .net_ctrl_irq_flag_in(nflag), .net_chan_attn_out(attn),
    .net_loopback_out(lb), .net_link_reset_out(lrst));

  vsi_host_model host_u (
    .mclk_in(mclk), .dtack_oe_in(dtk), .addr_out(va), .am_out(am),
    .as_n_out(as_n), .ds0_n_out(ds0_n), .ds1_n_out(ds1_n),
    .lword_n_out(lw_n), .write_n_out(wr_n), .iack_n_out(iack_n),
    .iackin_n_out(iackin_n), .data_out(hd));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  function automatic logic [31:0] adr(input logic [17:0] o);
    return a32 ? {base, o} : {8'h00, base[5:0], o};
  endfunction

  function automatic logic [5:0] amd();
    return a32 ? `VSI_AM_A32_DATA : `VSI_AM_A24_DATA;
  endfunction

  // Reads note {mask, expected} for the watcher before the cycle starts
  task automatic acc(input logic [17:0] o, input logic [3:0] c,
    input logic [31:0] d, input logic [63:0] x, input logic ak);
    if (c[2] && ak) begin
      q.push_back(x);
    end
    host_u.cyc(adr(o), amd(), c, 1'b0, d, ok);
    chk({31'h0, ok}, {31'h0, ak});
  endtask

  task automatic iack(input logic [2:0] lv, input logic [7:0] x,
    input logic ak);
    if (ak) begin
      q.push_back({32'h0000_00FF, 24'h0, x});
    end
    host_u.cyc({28'h0, lv, 1'b0}, amd(), 4'b1110, 1'b1, 32'h0, ok);
    chk({31'h0, ok}, {31'h0, ak});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    dt_q <= dtk;
    nseen <= nrst_n && (nseen || attn);
    if (dsel) begin
      dreg <= {dwr, dadr, dwd};
    end
    if (dtk && !dt_q && wr_n) begin
      if (q.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        e = q.pop_front();
        chk(vdo & e[63:32], e[31:0]);
      end
    end
  end

  // Whole sequence needs a few hundred clocks; allow ample margin
  initial begin
    #(20 * 50_000);
    err_total++;
    results();
  end

  initial begin
    host_u.init();
    seed = 958;
    {nrst_n, a32, dirq, nflag} = 4'h0;
    err_total = 0;
    samples_checked = 0;
    r = $random(seed);
    base = r[13:0];
    drd = r[21:14];
    ofs = '{18'h0_0000, 18'h0_FFFC, 18'h2_0000, 18'h3_FFFC};
    repeat (2) @(posedge mclk);
    nrst_n <= 1'b1;
    @(posedge mclk);
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      acc(ofs[i], 4'b0000, r, 64'h0, 1'b1);
      acc(ofs[i], 4'b0100, 32'h0, {32'hFFFF_FFFF, r}, 1'b1);
    end
    $display("test buffers done");
    acc(18'h2_0010, 4'b0000, 32'h0, 64'h0, 1'b1);
    acc(18'h2_0012, 4'b1010, 32'h0000_00A5, 64'h0, 1'b1);
    acc(18'h2_0012, 4'b1001, 32'h0000_5A00, 64'h0, 1'b1);
    acc(18'h2_0010, 4'b1000, 32'h0000_1234, 64'h0, 1'b1);
    acc(18'h2_0010, 4'b0100, 32'h0, {MSK, 32'h1234_5AA5}, 1'b1);
    acc(18'h2_0010, 4'b1100, 32'h0, {MSK, 32'h1234_1234}, 1'b1);
    $display("test lanes done");
    acc(18'h1_0008, 4'b0100, 32'h0, 64'h0, 1'b0);
    acc(18'h1_FF00, 4'b0100, 32'h0, 64'h0, 1'b0);
    host_u.cyc(adr(18'h0), 6'h3F, 4'b0100, 1'b0, 32'h0, ok);
    chk({31'h0, ok}, 32'h0);
    host_u.cyc(adr(18'h0), 6'h09, 4'b0100, 1'b0, 32'h0, ok);
    chk({31'h0, ok}, 32'h0);
    $display("test refusals done");
    dirq <= 1'b1;
    repeat (8) @(posedge mclk);
    dirq <= 1'b0;
    repeat (8) @(posedge mclk);
    chk({30'h0, irq3, irq2}, 32'h1);
    iack(3'h2, ID_D, 1'b1);
    chk({29'h0, iko_n, irq3, irq2}, 32'h5);
    acc(18'h1_0003, 4'b1100, 32'h0, {MSK, {4{drd}}}, 1'b1);
    repeat (4) @(posedge mclk);
    chk({30'h0, irq3, irq2}, 32'h0);
    iack(3'h2, ID_D, 1'b0);
    chk({31'h0, iko_n}, 32'h0);
    acc(18'h1_0005, 4'b1010, 32'h0000_00C3, 64'h0, 1'b1);
    chk({20'h0, dreg}, 32'h0000_0DC3);
    $display("test disk request done");
    nflag <= 1'b1;
    repeat (8) @(posedge mclk);
    chk({30'h0, irq3, irq2}, 32'h0);
    acc(18'h1_FF02, 4'b1000, 32'h0000_1000, 64'h0, 1'b1);
    repeat (4) @(posedge mclk);
    chk({27'h0, lrst, lb, nseen, irq3, irq2}, 32'h2);
    acc(18'h1_FF02, 4'b1100, 32'h0, {MSK, 32'h1100_1100}, 1'b1);
    iack(3'h3, ID_N, 1'b1);
    nflag <= 1'b0;
    acc(18'h1_FF02, 4'b1000, 32'h0000_E000, 64'h0, 1'b1);
    repeat (4) @(posedge mclk);
    chk({30'h0, irq3, irq2}, 32'h0);
    chk({29'h0, lrst, lb, nseen}, 32'h7);
    $display("test network request done");
    a32 <= 1'b1;
    @(posedge mclk);
    r = $random(seed);
    acc(18'h2_0004, 4'b0000, r, 64'h0, 1'b1);
    acc(18'h2_0004, 4'b0100, 32'h0, {32'hFFFF_FFFF, r}, 1'b1);
    host_u.cyc(adr(18'h0), 6'h39, 4'b0100, 1'b0, 32'h0, ok);
    chk({31'h0, ok}, 32'h0);
    $display("test wide addressing done");
    repeat (4) @(posedge mclk);
    results();
  end
endmodule

// >>> tb/vsi_host_model.sv
/*
 Backplane master model: runs single addressed cycles for the bench.
 Assumes the slave answers on dtack_oe_in within 16 clocks.
*/
`timescale 1ns/1ps
module vsi_host_model (
  // Clock and answer
  input wire logic mclk_in,
  input wire logic dtack_oe_in,
  // Address and control
  output logic [31:1] addr_out,
  output logic [5:0] am_out,
  output logic as_n_out,
  output logic ds0_n_out,
  output logic ds1_n_out,
  output logic lword_n_out,
  output logic write_n_out,
  output logic iack_n_out,
  output logic iackin_n_out,
  // Data
  output logic [31:0] data_out
);
  // Called once at time zero by the bench, so one process drives the pins
  task automatic init();
    addr_out = '0;
    am_out = 6'h00;
    {as_n_out, ds0_n_out, ds1_n_out, lword_n_out} = 4'hF;
    {write_n_out, iack_n_out, iackin_n_out} = 3'h7;
    data_out = 32'h0000_0000;
  endtask

  // One address phase, one data phase, then full release
  // c is {lword_n, write_n, ds1_n, ds0_n}
  task automatic cyc(input logic [31:0] a, input logic [5:0] am,
    input logic [3:0] c, input logic ia, input logic [31:0] d,
    output logic ok);
    int n;
    @(posedge mclk_in);
    addr_out <= a[31:1];
    am_out <= am;
    lword_n_out <= c[3];
    write_n_out <= c[2];
    iack_n_out <= !ia;
    iackin_n_out <= !ia;
    // A read leaves the data lines to the slave; show a moving pattern
    data_out <= c[2] ? ~data_out : d;
    as_n_out <= 1'b0;
    @(posedge mclk_in);
    ds1_n_out <= c[1];
    ds0_n_out <= c[0];
    ok = 1'b0;
    n = 0;
    while (n < 16 && !ok) begin
      @(posedge mclk_in);
      ok = dtack_oe_in;
      n++;
    end
    ds1_n_out <= 1'b1;
    ds0_n_out <= 1'b1;
    n = 0;
    while (n < 16 && dtack_oe_in) begin
      @(posedge mclk_in);
      n++;
    end
    as_n_out <= 1'b1;
    data_out <= ~d;
  endtask
endmodule
